// [hw/qbs_mem_ctl.sv]
// Controller end: turns whole-burst user requests into link commands and beats.
// Assumes the user side runs on the same clk; link beats are driven from registers.
`timescale 1ns/100ps
module qbs_mem_ctl #(
    parameter int DW = qbs_pkg::DATA_W,
    parameter int BW = qbs_pkg::BWS_W,
    parameter int AW = qbs_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the memory port
    qbs_link_if.ctl lnk,
    // Link clock control
    input wire logic clock_stop,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [AW-1:0] req_addr,
    input wire logic [4*DW-1:0] req_wdata,
    input wire logic [4*BW-1:0] req_wmask_n,
    // Read response
    output logic rsp_valid,
    output logic [4*DW-1:0] rsp_rdata
);
    typedef struct packed {
        logic nxt_pos;
        logic k_run;
        logic k_pos;
        logic prev_run;
        logic rps_n;
        logic wps_n;
        logic [AW-1:0] addr;
        logic [DW-1:0] d;
        logic [BW-1:0] bws_n;
        logic hold_v;
        logic hold_wr;
        logic [AW-1:0] hold_a;
        logic [4*DW-1:0] hold_d;
        logic [4*BW-1:0] hold_m;
        logic last_rd;
        logic last_wr;
        logic wr_pend;
        logic [4*DW-1:0] pend_d;
        logic [4*BW-1:0] pend_m;
        logic wr_act;
        logic [qbs_pkg::IDX_W-1:0] wr_idx;
        logic [4*DW-1:0] act_d;
        logic [4*BW-1:0] act_m;
        logic [qbs_pkg::IDX_W-1:0] rcnt;
        logic [4*DW-1:0] rbuf;
        logic rsp_v;
    } qbs_ctl_state_type;

    qbs_ctl_state_type s_q;
    qbs_ctl_state_type s_d;
    logic wr_issue;

    // Next state: request intake, command issue, write beats, read capture
    always_comb begin
        s_d = s_q;
        wr_issue = 1'b0;
        s_d.rsp_v = 1'b0;
        s_d.rps_n = qbs_pkg::SEL_IDLE_N;
        s_d.wps_n = qbs_pkg::SEL_IDLE_N;
        s_d.bws_n = '1;
        s_d.prev_run = s_q.k_run;
        s_d.k_run = !clock_stop;
        if (req_valid && !s_q.hold_v) begin
            s_d.hold_v = 1'b1;
            s_d.hold_wr = req_write;
            s_d.hold_a = req_addr;
            s_d.hold_d = req_wdata;
            s_d.hold_m = req_wmask_n;
        end
        // Next beat presented only while the clock runs
        if (!clock_stop) begin
            s_d.k_pos = s_q.nxt_pos;
            s_d.nxt_pos = !s_q.nxt_pos;
            if (s_q.nxt_pos) begin
                s_d.last_rd = 1'b0;
                s_d.last_wr = 1'b0;
                // Never the same type on consecutive positive beats
                if (s_q.hold_v && !s_q.hold_wr && !s_q.last_rd) begin
                    s_d.rps_n = 1'b0;
                    s_d.addr = s_q.hold_a;
                    s_d.hold_v = 1'b0;
                    s_d.last_rd = 1'b1;
                end else if (s_q.hold_v && s_q.hold_wr && !s_q.last_wr) begin
                    s_d.wps_n = 1'b0;
                    s_d.addr = s_q.hold_a;
                    s_d.hold_v = 1'b0;
                    s_d.last_wr = 1'b1;
                    wr_issue = 1'b1;
                end
            end
            // Write words on the four beats from the next positive beat after the start cycle
            if (s_q.nxt_pos && s_q.wr_pend) begin
                s_d.d = s_q.pend_d[0 +: DW];
                s_d.bws_n = s_q.pend_m[0 +: BW];
                s_d.act_d = s_q.pend_d;
                s_d.act_m = s_q.pend_m;
                s_d.wr_act = 1'b1;
                s_d.wr_idx = 2'h1;
            end else if (s_q.wr_act) begin
                s_d.d = s_q.act_d[s_q.wr_idx*DW +: DW];
                s_d.bws_n = s_q.act_m[s_q.wr_idx*BW +: BW];
                s_d.wr_idx = s_q.wr_idx + 1'b1;
                s_d.wr_act = (s_q.wr_idx != qbs_pkg::LAST_IDX);
            end
            if (s_q.nxt_pos) begin
                s_d.wr_pend = wr_issue;
                if (wr_issue) begin
                    s_d.pend_d = s_q.hold_d;
                    s_d.pend_m = s_q.hold_m;
                end
            end
        end
        // Capture read words launched on the last running beat
        if (s_q.prev_run && !lnk.q_oe_n) begin
            s_d.rbuf[s_q.rcnt*DW +: DW] = lnk.q;
            s_d.rcnt = s_q.rcnt + 1'b1;
            s_d.rsp_v = (s_q.rcnt == qbs_pkg::LAST_IDX);
        end
    end

    // State register; selects idle at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.nxt_pos <= qbs_pkg::FIRST_POS;
            s_q.rps_n <= qbs_pkg::SEL_IDLE_N;
            s_q.wps_n <= qbs_pkg::SEL_IDLE_N;
            s_q.bws_n <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // Link and user outputs
    assign lnk.k_run = s_q.k_run;
    assign lnk.k_pos = s_q.k_pos;
    assign lnk.addr = s_q.addr;
    assign lnk.read_port_select_n = s_q.rps_n;
    assign lnk.write_port_select_n = s_q.wps_n;
    assign lnk.d = s_q.d;
    assign lnk.byte_write_select_n = s_q.bws_n;
    assign req_ready = !s_q.hold_v;
    assign rsp_valid = s_q.rsp_v;
    assign rsp_rdata = s_q.rbuf;
endmodule : qbs_mem_ctl

// [hw/qbs_pkg.sv]
// Shared constants of the four-word burst memory port and its controller.
// Assumes one system clock; each link beat is one clock cycle with the link running.
package qbs_pkg;
    // Default geometry of the memory array
    localparam int DATA_W = 18;
    localparam int BWS_W = 2;
    localparam int ADDR_W = 6;
    // Words per burst and index width
    localparam int BURST_LEN = 4;
    localparam int IDX_W = 2;
    localparam logic [IDX_W-1:0] LAST_IDX = 2'h3;
    localparam logic [IDX_W-1:0] FIRST_IDX = 2'h0;
    // Reset values of the command pins and the link
    localparam logic SEL_IDLE_N = 1'h1;
    localparam logic OE_OFF_N = 1'h1;
    localparam logic FIRST_POS = 1'h1;
endpackage : qbs_pkg

// [hw/qbs_link_if.sv]
// Link between the burst memory port and its controller.
// Assumes both ends run on the same clk; a beat happens on each clk edge with k_run high.
`timescale 1ns/100ps
interface qbs_link_if #(
    parameter int DW = qbs_pkg::DATA_W,
    parameter int BW = qbs_pkg::BWS_W,
    parameter int AW = qbs_pkg::ADDR_W
);
    // Link clock state: running, and positive-clock beat
    logic k_run;
    logic k_pos;
    // Command and write data from the controller
    logic [AW-1:0] addr;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [DW-1:0] d;
    logic [BW-1:0] byte_write_select_n;
    // Read data from the memory port
    // Read data counts as floating whenever q_oe_n is high
    logic [DW-1:0] q;
    logic q_oe_n;

    modport mem (
        input k_run, k_pos, addr, read_port_select_n, write_port_select_n, d,
        input byte_write_select_n,
        output q, q_oe_n
    );
    modport ctl (
        output k_run, k_pos, addr, read_port_select_n, write_port_select_n, d,
        output byte_write_select_n,
        input q, q_oe_n
    );
endinterface : qbs_link_if

// [hw/qbs_mem_port.sv]
// Memory port end: separate read and write ports, four-word bursts, two beats per cycle.
// Assumes the controller on the link presents each beat in one clk cycle on the same clk.
`timescale 1ns/100ps
module qbs_mem_port #(
    parameter int DW = qbs_pkg::DATA_W,
    parameter int BW = qbs_pkg::BWS_W,
    parameter int AW = qbs_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the controller
    qbs_link_if.mem lnk,
    // User side: status of the port
    output logic read_busy,
    output logic write_busy,
    output logic idle_cycle
);
    localparam int LW = DW / BW;
    localparam int DEPTH = 1 << AW;

    typedef struct packed {
        logic last_rd;
        logic last_wr;
        logic rd_pend;
        logic [AW-1:0] rd_pend_a;
        logic rd_wait;
        logic [AW-1:0] rd_wait_a;
        logic rd_act;
        logic [qbs_pkg::IDX_W-1:0] rd_idx;
        logic [AW-1:0] rd_a;
        logic wr_pend;
        logic [AW-1:0] wr_pend_a;
        logic wr_act;
        logic [qbs_pkg::IDX_W-1:0] wr_idx;
        logic [AW-1:0] wr_a;
        logic [DW-1:0] q;
        logic q_oe_n;
        logic idle;
        logic [DEPTH-1:0][DW-1:0] mem;
    } qbs_mem_state_type;

    qbs_mem_state_type s_q;
    qbs_mem_state_type s_d;
    logic rd_go;
    logic wr_go;
    logic wr_do;
    logic rd_do;
    logic [AW-1:0] wr_base;
    logic [AW-1:0] rd_base;
    logic [qbs_pkg::IDX_W-1:0] wr_i;
    logic [qbs_pkg::IDX_W-1:0] rd_i;
    logic [AW-1:0] wr_x;
    logic [AW-1:0] rd_x;

    // Next state: start decode, write beats, read beats
    always_comb begin
        s_d = s_q;
        rd_go = 1'b0;
        wr_go = 1'b0;
        wr_do = 1'b0;
        rd_do = 1'b0;
        wr_base = s_q.wr_a;
        rd_base = s_q.rd_a;
        wr_i = s_q.wr_idx;
        rd_i = s_q.rd_idx;
        wr_x = '0;
        rd_x = '0;
        // Nothing moves while the link clock is stopped
        if (lnk.k_run) begin
            if (lnk.k_pos) begin
                // Read wins a tie unless a read started on the last positive beat
                rd_go = !lnk.read_port_select_n && !s_q.last_rd;
                // Read select is a don't care after a read start
                wr_go = !lnk.write_port_select_n && !s_q.last_wr && !rd_go;
                s_d.last_rd = rd_go;
                s_d.last_wr = wr_go;
                s_d.idle = lnk.read_port_select_n && lnk.write_port_select_n;
            end
            // Write beat: first word on the next positive beat, two edges after the start
            if (lnk.k_pos && s_q.wr_pend) begin
                wr_do = 1'b1;
                wr_base = s_q.wr_pend_a;
                wr_i = qbs_pkg::FIRST_IDX;
            end else if (s_q.wr_act) begin
                wr_do = 1'b1;
            end
            if (wr_do) begin
                wr_x = AW'(wr_base + AW'(wr_i));
                // Each lane stored only when its select is low
                for (int l = 0; l < BW; l++) begin
                    if (!lnk.byte_write_select_n[l]) begin
                        s_d.mem[wr_x][l*LW +: LW] = lnk.d[l*LW +: LW];
                    end
                end
                s_d.wr_a = wr_base;
                s_d.wr_idx = wr_i + 1'b1;
                s_d.wr_act = (wr_i != qbs_pkg::LAST_IDX);
            end
            // Read beat: first word two cycles after the start
            if (lnk.k_pos && s_q.rd_wait) begin
                rd_do = 1'b1;
                rd_base = s_q.rd_wait_a;
                rd_i = qbs_pkg::FIRST_IDX;
            end else if (s_q.rd_act) begin
                rd_do = 1'b1;
            end
            if (rd_do) begin
                rd_x = AW'(rd_base + AW'(rd_i));
                s_d.q = s_q.mem[rd_x];
                s_d.q_oe_n = 1'b0;
                s_d.rd_a = rd_base;
                s_d.rd_idx = rd_i + 1'b1;
                s_d.rd_act = (rd_i != qbs_pkg::LAST_IDX);
            end else begin
                // Outputs float between bursts
                s_d.q_oe_n = qbs_pkg::OE_OFF_N;
            end
            // Pipeline of latched addresses, advanced on positive beats
            if (lnk.k_pos) begin
                s_d.rd_wait = s_q.rd_pend;
                s_d.rd_wait_a = s_q.rd_pend_a;
                s_d.rd_pend = rd_go;
                s_d.wr_pend = wr_go;
                if (rd_go) begin
                    s_d.rd_pend_a = lnk.addr;
                end
                if (wr_go) begin
                    s_d.wr_pend_a = lnk.addr;
                end
            end
        end
    end

    // State register; powers up deselected with outputs off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.q_oe_n <= qbs_pkg::OE_OFF_N;
            s_q.idle <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign lnk.q = s_q.q;
    assign lnk.q_oe_n = s_q.q_oe_n;
    assign read_busy = s_q.rd_pend | s_q.rd_wait | s_q.rd_act;
    assign write_busy = s_q.wr_pend | s_q.wr_act;
    assign idle_cycle = s_q.idle;
endmodule : qbs_mem_port

// [testbench/qbs_link_properties.sv]
// Checker of the link between the burst memory port and its controller.
// Assumes one clk; a beat happens on each clk edge with k_run high.
`timescale 1ns/100ps
module qbs_link_properties #(
    parameter int DW = qbs_pkg::DATA_W,
    parameter int BW = qbs_pkg::BWS_W,
    parameter int AW = qbs_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link signals
    input wire logic k_run,
    input wire logic k_pos,
    input wire logic [AW-1:0] addr,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [DW-1:0] d,
    input wire logic [BW-1:0] byte_write_select_n,
    input wire logic [DW-1:0] q,
    input wire logic q_oe_n
);
    logic [7:0] rd_hist_q;
    logic rd_prev_q;
    logic wr_prev_q;
    logic last_pos_q;
    logic rd_go;
    logic wr_go;

    // Starts as the port takes them
    assign rd_go = k_run && k_pos && !read_port_select_n && !rd_prev_q;
    assign wr_go = k_run && k_pos && !write_port_select_n && !wr_prev_q && !rd_go;

    // Beat history of read starts, last start per type
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_hist_q <= 8'h00;
            rd_prev_q <= 1'h0;
            wr_prev_q <= 1'h0;
            last_pos_q <= 1'h0;
        end else if (k_run) begin
            rd_hist_q <= {rd_hist_q[6:0], rd_go};
            last_pos_q <= k_pos;
            if (k_pos) begin
                rd_prev_q <= rd_go;
                wr_prev_q <= wr_go;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    rd_window_a: assert property (q_oe_n == !(|rd_hist_q[7:4]))
        else $error("read outputs not driven on beats four to seven");
    rd_latency_a: assert property (rd_go |-> ##[4:40] !q_oe_n)
        else $error("read start gave no read data");
    burst_len_a: assert property ($fell(q_oe_n) |-> !q_oe_n [*4])
        else $error("read burst cut short");
    idle_hiz_a: assert property (q_oe_n && k_run && read_port_select_n
        && rd_hist_q[3:0] == 4'h0 |=> q_oe_n)
        else $error("outputs driven without a read");
    stop_hold_a: assert property (!k_run |=> $stable(q) && $stable(q_oe_n))
        else $error("outputs changed with link clock stopped");
    beat_alt_a: assert property (k_run |-> k_pos != last_pos_q)
        else $error("positive and negative beats not alternating");
    rd_b2b_a: assert property (k_run && k_pos && rd_prev_q |-> read_port_select_n)
        else $error("read requested on consecutive positive beats");
    wr_b2b_a: assert property (k_run && k_pos && wr_prev_q |-> write_port_select_n)
        else $error("write requested on consecutive positive beats");
    wr_start_a: assert property (wr_go |-> read_port_select_n || rd_prev_q)
        else $error("write started with read select low");
endmodule : qbs_link_properties

// [testbench/testbench.sv]
// Testbench of the memory port and controller joined by the link.
// Assumes the package, interface and both ends are compiled first; clk is 10 MHz.
`timescale 1ns/100ps
module testbench;
    localparam int DW = qbs_pkg::DATA_W;
    localparam int BW = qbs_pkg::BWS_W;
    localparam int AW = qbs_pkg::ADDR_W;
    localparam int LW = DW / BW;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic clock_stop = 1'h0;
    logic req_valid = 1'h0;
    logic req_write = 1'h0;
    logic [AW-1:0] req_addr = '0;
    logic [4*DW-1:0] req_wdata = '0;
    logic [4*BW-1:0] req_wmask_n = '1;
    logic req_ready, rsp_valid, read_busy, write_busy, idle_cycle;
    logic [4*DW-1:0] rsp_rdata;
    logic [DW-1:0] exp_mem [2**AW];
    int error_cnt = 0;
    int checks = 0;

    qbs_link_if lnk ();
    qbs_mem_port qbs_mem_port_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk.mem),
        .read_busy(read_busy), .write_busy(write_busy), .idle_cycle(idle_cycle));
    qbs_mem_ctl qbs_mem_ctl_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk.ctl),
        .clock_stop(clock_stop), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_wmask_n(req_wmask_n), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    qbs_link_properties #(.DW(DW), .BW(BW), .AW(AW)) qbs_link_properties_inst (
        .clk(clk), .rst_n(rst_n), .k_run(lnk.k_run), .k_pos(lnk.k_pos),
        .addr(lnk.addr), .read_port_select_n(lnk.read_port_select_n),
        .write_port_select_n(lnk.write_port_select_n), .d(lnk.d),
        .byte_write_select_n(lnk.byte_write_select_n), .q(lnk.q), .q_oe_n(lnk.q_oe_n));

    // Clock
    always #50 clk = ~clk;

    // Compare and count
    task automatic check(input logic [4*DW-1:0] seen, input logic [4*DW-1:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Let n edges pass, then step off the edge
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // Hand one burst request to the controller; writes update the model
    task automatic request(input logic wr, input logic [AW-1:0] a,
                           input logic [4*DW-1:0] w, input logic [4*BW-1:0] m);
        logic rdy;
        logic [AW-1:0] ak;
        int n;
        rdy = 1'h0;
        n = 0;
        // Let one edge pass with valid low between requests
        idle(1);
        req_valid = 1'h1;
        req_write = wr;
        req_addr = a;
        req_wdata = w;
        req_wmask_n = m;
        while (!rdy && n < 100) begin
            @(negedge clk);
            rdy = req_ready;
            idle(1);
            n++;
        end
        req_valid = 1'h0;
        if (!rdy) begin
            error_cnt++;
            $display("FAIL %0t request not taken", $time);
        end
        for (int k = 0; k < 4; k++) begin
            ak = a + AW'(k);
            for (int l = 0; l < BW; l++) begin
                if (wr && !m[k*BW+l]) begin
                    exp_mem[ak][l*LW+:LW] = w[k*DW+l*LW+:LW];
                end
            end
        end
    endtask : request

    // Read a burst, optionally stopping the link clock meanwhile
    task automatic read_chk(input logic [AW-1:0] a, input int stop);
        logic [4*DW-1:0] exp;
        int n;
        for (int k = 0; k < 4; k++) begin
            exp[k*DW+:DW] = exp_mem[a+AW'(k)];
        end
        request(1'h0, a, '0, '1);
        if (stop > 0) begin
            clock_stop = 1'h1;
            idle(stop);
            clock_stop = 1'h0;
        end
        n = 0;
        while (rsp_valid !== 1'h1 && n < 60) begin
            idle(1);
            n++;
        end
        if (rsp_valid !== 1'h1) begin
            error_cnt++;
            $display("FAIL %0t read response missing", $time);
        end
        check(rsp_rdata, exp);
    endtask : read_chk

    // Watchdog
    initial begin
        #300000;
        error_cnt++;
        $display("FAIL %0t run did not finish", $time);
        end_of_test();
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            exp_mem[i] = '0;
        end
        idle(4);
        check((4*DW)'({lnk.q_oe_n, idle_cycle, req_ready, rsp_valid, read_busy, write_busy}),
              (4*DW)'(6'h38));
        rst_n = 1'h1;
        // Full burst wrapping past the top address
        request(1'h1, 6'h3e, 72'h0123456789abcdef01, 8'h00);
        // Preload, then one masked write with a different select per beat
        request(1'h1, 6'h10, 72'hfedcba9876543210fe, 8'h00);
        request(1'h1, 6'h10, 72'h5a5a5a5a5a5a5a5a5a, 8'hd8);
        // Writes handed over back to back
        for (int i = 0; i < 4; i++) begin
            request(1'h1, AW'(6'h20 + 4 * i),
                    {DW'(4 * i + 3), DW'(4 * i + 2), DW'(4 * i + 1), DW'(4 * i + 9)}, 8'h00);
        end
        idle(20);
        read_chk(6'h3e, 0);
        read_chk(6'h10, 0);
        for (int i = 0; i < 4; i++) begin
            read_chk(AW'(6'h20 + 4 * i), i + 2);
        end
        idle(12);
        check((4*DW)'({read_busy, write_busy, idle_cycle, lnk.q_oe_n}), (4*DW)'(4'h3));
        end_of_test();
    end
endmodule : testbench
